//--- host_req_map.svh
// constants for the host request pin logic
`ifndef HOST_REQ_MAP_SVH
`define HOST_REQ_MAP_SVH
`define HRQ_POL_RESET 1'b0
`define HRQ_OD_RESET 1'b0
`define HRQ_FUNC_RESET 1'b0
`define HRQ_DBL_RESET 1'b0
`define HRQ_DIR_RESET 2'h0
`define HRQ_DIR_DISC 2'h0
`define HRQ_DIR_IN 2'h1
`define HRQ_DIR_OUT 2'h2
`endif

//--- host_req_pkg.sv
// types for the host request pin logic
package host_req_pkg;
    typedef enum logic [1:0] {
        GP_DISC = 2'h0,
        GP_IN = 2'h1,
        GP_OUT = 2'h2,
        GP_RSVD = 2'h3
    } gp_dir_e;
endpackage : host_req_pkg

//--- req_pin_drive.sv
// one request pin driver: polarity and driven or open-drain style
module req_pin_drive (
    input wire logic req_active,
    input wire logic active_high,
    input wire logic open_drain,
    output logic pin_level,
    output logic pin_oe
);
    wire logic level_w;
    assign level_w = req_active ? active_high : ~active_high;
    // open drain only pulls low, else released
    assign pin_level = open_drain ? 1'b0 : level_w;
    assign pin_oe = open_drain ? ~level_w : 1'b1;
endmodule : req_pin_drive

//--- host_request_pin_logic.sv
// request and acknowledge pin logic of the parallel host port
`include "host_req_map.svh"
module host_request_pin_logic (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic host_port_function,
    input wire logic double_request,
    input wire logic single_req_high,
    input wire logic tx_req_high,
    input wire logic rx_req_high,
    input wire logic ack_high,
    input wire logic single_req_od,
    input wire logic tx_req_od,
    input wire logic rx_req_od,
    input wire logic [1:0] dir_fourteen,
    input wire logic [1:0] dir_fifteen,
    input wire logic out_fourteen,
    input wire logic out_fifteen,
    input wire logic single_req,
    input wire logic tx_req,
    input wire logic rx_req,
    input wire logic port_line_fourteen_in,
    input wire logic port_line_fifteen_in,
    output logic port_line_fourteen_out,
    output logic port_line_fourteen_oe,
    output logic port_line_fifteen_out,
    output logic port_line_fifteen_oe,
    output logic host_acknowledge_in,
    output logic gp_in_fourteen,
    output logic gp_in_fifteen
);
    logic func_reg;
    logic dbl_reg;
    logic pol_s_reg;
    logic pol_t_reg;
    logic pol_r_reg;
    logic pol_a_reg;
    logic od_s_reg;
    logic od_t_reg;
    logic od_r_reg;
    host_req_pkg::gp_dir_e dir14_reg;
    host_req_pkg::gp_dir_e dir15_reg;
    logic ack_reg;
    logic gp14_reg;
    logic gp15_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            func_reg <= `HRQ_FUNC_RESET;
            dbl_reg <= `HRQ_DBL_RESET;
            pol_s_reg <= `HRQ_POL_RESET;
            pol_t_reg <= `HRQ_POL_RESET;
            pol_r_reg <= `HRQ_POL_RESET;
            pol_a_reg <= `HRQ_POL_RESET;
            od_s_reg <= `HRQ_OD_RESET;
            od_t_reg <= `HRQ_OD_RESET;
            od_r_reg <= `HRQ_OD_RESET;
            dir14_reg <= host_req_pkg::gp_dir_e'(`HRQ_DIR_RESET);
            dir15_reg <= host_req_pkg::gp_dir_e'(`HRQ_DIR_RESET);
        end
        else
        begin
            func_reg <= host_port_function;
            dbl_reg <= double_request;
            pol_s_reg <= single_req_high;
            pol_t_reg <= tx_req_high;
            pol_r_reg <= rx_req_high;
            pol_a_reg <= ack_high;
            od_s_reg <= single_req_od;
            od_t_reg <= tx_req_od;
            od_r_reg <= rx_req_od;
            dir14_reg <= host_req_pkg::gp_dir_e'(dir_fourteen);
            dir15_reg <= host_req_pkg::gp_dir_e'(dir_fifteen);
        end
    end

    // line 14 request selection
    wire logic req14_w;
    wire logic pol14_w;
    wire logic od14_w;
    assign req14_w = dbl_reg ? tx_req : single_req;
    assign pol14_w = dbl_reg ? pol_t_reg : pol_s_reg;
    assign od14_w = dbl_reg ? od_t_reg : od_s_reg;

    wire logic hi14_lvl;
    wire logic hi14_oe;
    wire logic hi15_lvl;
    wire logic hi15_oe;
    req_pin_drive u_drv14 (
        .req_active(req14_w),
        .active_high(pol14_w),
        .open_drain(od14_w),
        .pin_level(hi14_lvl),
        .pin_oe(hi14_oe)
    );
    req_pin_drive u_drv15 (
        .req_active(rx_req),
        .active_high(pol_r_reg),
        .open_drain(od_r_reg),
        .pin_level(hi15_lvl),
        .pin_oe(hi15_oe)
    );

    wire logic gp14_out_w;
    wire logic gp15_out_w;
    wire logic hi15_drive_w;
    assign gp14_out_w = (dir14_reg == host_req_pkg::GP_OUT);
    assign gp15_out_w = (dir15_reg == host_req_pkg::GP_OUT);
    assign hi15_drive_w = func_reg && dbl_reg;
    assign port_line_fourteen_out = func_reg ? hi14_lvl : out_fourteen;
    assign port_line_fourteen_oe = func_reg ? hi14_oe : gp14_out_w;
    assign port_line_fifteen_out = hi15_drive_w ? hi15_lvl : out_fifteen;
    // single mode: line 15 is an input, never driven
    assign port_line_fifteen_oe = func_reg ? (dbl_reg && hi15_oe)
                                           : gp15_out_w;

    // acknowledge sampling, polarity removed
    wire logic ack_next;
    wire logic gp14_next;
    wire logic gp15_next;
    assign ack_next = func_reg && !dbl_reg
                      && (port_line_fifteen_in == pol_a_reg);
    assign gp14_next = !func_reg && (dir14_reg == host_req_pkg::GP_IN)
                       ? port_line_fourteen_in : 1'b0;
    assign gp15_next = !func_reg && (dir15_reg == host_req_pkg::GP_IN)
                       ? port_line_fifteen_in : 1'b0;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_reg <= 1'b0;
            gp14_reg <= 1'b0;
            gp15_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= ack_next;
            gp14_reg <= gp14_next;
            gp15_reg <= gp15_next;
        end
    end
    assign host_acknowledge_in = ack_reg;
    assign gp_in_fourteen = gp14_reg;
    assign gp_in_fifteen = gp15_reg;

    chk_reset_disc: assert property (@(posedge clk)
        $past(sys_rst) |-> !port_line_fourteen_oe && !port_line_fifteen_oe)
        else $error("lines driven right after reset");
    chk_reset_quiet: assert property (@(posedge clk)
        $past(sys_rst) |-> !host_acknowledge_in && !gp_in_fourteen
        && !gp_in_fifteen)
        else $error("inputs sampled right after reset");
    chk_single_drive: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && !dbl_reg && !od_s_reg |-> port_line_fourteen_oe
        && port_line_fourteen_out == (single_req ~^ pol_s_reg))
        else $error("single request level wrong");
    chk_driven_oe: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && !od14_w |-> port_line_fourteen_oe)
        else $error("driven request line not enabled");
    chk_tx_level: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && dbl_reg && !od_t_reg |->
        port_line_fourteen_out == (tx_req ~^ pol_t_reg))
        else $error("transmit request level wrong");
    chk_rx_level: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && dbl_reg && !od_r_reg |-> port_line_fifteen_oe
        && port_line_fifteen_out == (rx_req ~^ pol_r_reg))
        else $error("receive request level wrong");
    chk_od_pull: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && od14_w |-> !port_line_fourteen_out
        && (port_line_fourteen_oe == !(req14_w ~^ pol14_w)))
        else $error("open drain behaviour wrong");
    chk_rx_od_pull: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && dbl_reg && od_r_reg |-> !port_line_fifteen_out
        && (port_line_fifteen_oe == !(rx_req ~^ pol_r_reg)))
        else $error("receive open drain behaviour wrong");
    chk_ack_input: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && !dbl_reg |-> !port_line_fifteen_oe
        ##1 host_acknowledge_in == $past(port_line_fifteen_in ~^ pol_a_reg))
        else $error("acknowledge line driven or lost");
    chk_ack_pol: assert property (@(posedge clk)
        disable iff (sys_rst)
        ##1 host_acknowledge_in == ($past(func_reg && !dbl_reg)
        && $past(port_line_fifteen_in) == $past(pol_a_reg)))
        else $error("acknowledge polarity wrong");
    chk_gp_dir: assert property (@(posedge clk)
        disable iff (sys_rst)
        !func_reg |->
        port_line_fourteen_oe == (dir14_reg == host_req_pkg::GP_OUT)
        && port_line_fifteen_oe == (dir15_reg == host_req_pkg::GP_OUT))
        else $error("general purpose direction wrong");
    chk_gp_sample: assert property (@(posedge clk)
        disable iff (sys_rst)
        !func_reg && dir14_reg == host_req_pkg::GP_IN
        |=> gp_in_fourteen == $past(port_line_fourteen_in))
        else $error("line 14 input not sampled");
    chk_gp_refused: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg |=> !gp_in_fourteen && !gp_in_fifteen)
        else $error("general purpose input seen in host function");
    chk_pol_state: assert property (@(posedge clk)
        disable iff (sys_rst)
        func_reg && dbl_reg && !od_t_reg && $stable(tx_req)
        && $stable({func_reg, dbl_reg, od_t_reg})
        && $changed(pol_t_reg) |-> $changed(port_line_fourteen_out))
        else $error("polarity change not seen at pin");
    cov_single: cover property (@(posedge clk) func_reg && !dbl_reg
        && single_req);
    cov_double: cover property (@(posedge clk) func_reg && dbl_reg
        && tx_req && rx_req);
    cov_ack: cover property (@(posedge clk) host_acknowledge_in);
    cov_gp: cover property (@(posedge clk) !func_reg && gp_in_fifteen);
    cov_open_drain: cover property (@(posedge clk) func_reg && od14_w
        && port_line_fourteen_oe);
endmodule : host_request_pin_logic

//--- host_model.sv
// host side model: pull-ups on both lines, acknowledge drive
module host_model (
    input wire logic out14,
    input wire logic oe14,
    input wire logic out15,
    input wire logic oe15,
    input wire logic ack_en,
    input wire logic ack_lvl,
    output logic pad14,
    output logic pad15
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released line floats high on its pull-up
    assign pad14 = oe14 ? out14 : 1'h1;
    assign pad15 = oe15 ? out15 : ack_en ? ack_lvl : 1'h1;
endmodule : host_model

//--- host_request_pin_logic_tb.sv
// self-checking bench for the host request pin logic
module host_request_pin_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, sys_rst, fn, dbl, sh, th, rh, ah, so, to, ro, o14, o15;
    logic sr, tr, rr, ae, al, p14, p15, q14, e14, q15, e15, ack, g14, g15;
    logic [1:0] d14, d15;
    int errors, comparisons, cycles;
    host_request_pin_logic i_host_request_pin_logic (.clk(clk),
        .sys_rst(sys_rst), .host_port_function(fn), .double_request(dbl),
        .single_req_high(sh), .tx_req_high(th), .rx_req_high(rh),
        .ack_high(ah), .single_req_od(so), .tx_req_od(to), .rx_req_od(ro),
        .dir_fourteen(d14), .dir_fifteen(d15), .out_fourteen(o14),
        .out_fifteen(o15), .single_req(sr), .tx_req(tr), .rx_req(rr),
        .port_line_fourteen_in(p14), .port_line_fifteen_in(p15),
        .port_line_fourteen_out(q14), .port_line_fourteen_oe(e14),
        .port_line_fifteen_out(q15), .port_line_fifteen_oe(e15),
        .host_acknowledge_in(ack), .gp_in_fourteen(g14),
        .gp_in_fifteen(g15));
    host_model i_host_model (.out14(q14), .oe14(e14), .out15(q15),
        .oe15(e15), .ack_en(ae), .ack_lvl(al), .pad14(p14), .pad15(p15));
    task chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
            $display("ERROR %0t got %h want %h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask : chk
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task test_done;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done
    task t_reset;
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        #1;
        chk({e14, e15, ack, g15}, 4'h0);
        chk(g14, 4'h0);
    endtask : t_reset
    task t_single;
        @(posedge clk);
        {fn, sr, ae, al} <= 4'hA;
        settle;
        chk({q14, e14, e15, ack}, 4'hD);
        @(posedge clk);
        sh <= 1'h1;
        settle;
        chk({q14, e14}, 4'h1);
        @(posedge clk);
        {so, sr, ae} <= 3'h5;
        settle;
        chk({e14, p14, ack}, 4'h5);
        @(posedge clk);
        {sr, ah} <= 2'h3;
        settle;
        chk({e14, p14, ack}, 4'h2);
        @(posedge clk);
        al <= 1'h1;
        settle;
        chk(ack, 4'h1);
    endtask : t_single
    task t_double;
        @(posedge clk);
        {dbl, tr, rr, al} <= 4'hC;
        {sh, so, ah, ae} <= 4'h0;
        settle;
        chk({q14, e14, q15, e15}, 4'h7);
        chk(ack, 4'h0);
        @(posedge clk);
        {th, rh, rr, ro} <= 4'hF;
        settle;
        chk({q14, e14, q15, e15}, 4'hC);
        @(posedge clk);
        {to, tr, rr} <= 3'h4;
        settle;
        chk({q14, e14, p14, e15}, 4'h5);
    endtask : t_double
    task t_gp;
        @(posedge clk);
        {fn, o14, al} <= 3'h3;
        d14 <= host_req_pkg::GP_OUT;
        d15 <= host_req_pkg::GP_IN;
        settle;
        chk({q14, e14, e15, g15}, 4'hD);
        @(posedge clk);
        d14 <= host_req_pkg::GP_IN;
        d15 <= host_req_pkg::GP_RSVD;
        settle;
        chk({e14, g14, e15, g15}, 4'h4);
        @(posedge clk);
        d14 <= host_req_pkg::GP_DISC;
        d15 <= host_req_pkg::GP_OUT;
        o15 <= 1'h1;
        settle;
        chk({e14, g14, q15, e15}, 4'h3);
    endtask : t_gp
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            test_done;
        end
    end
    initial
    begin
        {sys_rst, fn, dbl, sh, th, rh, ah, so, to, ro} = 10'h200;
        {o14, o15, sr, tr, rr, ae, al, d14, d15} = 11'h0;
        t_reset;
        t_single;
        t_double;
        t_gp;
        t_reset;
        test_done;
    end
endmodule : host_request_pin_logic_tb
